// ---- rtl/plsr_pkg.sv ----
// Purpose: Shared constants and types for the link status/receive port
// Assumes: Two control lines and an eight-line data bus toward the link
// Notes: Register map for the software port lives here
package plsr_pkg;
    localparam logic [1:0] CTL_IDLE = 2'h0;
    localparam logic [1:0] CTL_STATUS = 2'h1;
    localparam logic [1:0] CTL_RECEIVE = 2'h2;
    localparam logic [7:0] D_DATA_ON = 8'hff;
    localparam logic [7:0] D_ZERO = 8'h00;
    localparam logic [7:0] SPD_S100 = 8'h00;
    localparam logic [7:0] SPD_S200 = 8'h40;
    localparam logic [7:0] SPD_S400 = 8'h50;
    localparam logic [1:0] SPEED_100 = 2'h0;
    localparam logic [1:0] SPEED_200 = 2'h1;
    localparam logic [1:0] SPEED_400 = 2'h2;
    localparam logic [2:0] FLAG_CYCLES = 3'h2;
    localparam logic [2:0] FULL_CYCLES = 3'h7;
    localparam logic [2:0] REG_LAST_CYCLE = 3'h7;
    // Register offsets of the software port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h1;
    localparam logic [3:0] REG_NODE = 4'h2;
    localparam logic [3:0] REG_REPORT = 4'h3;
    localparam logic [3:0] REG_RXCNT = 4'h4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_FLAGS_LSB = 4;
    localparam int REPORT_PEND_BIT = 12;

    typedef struct packed {
        logic [1:0] ctl;
        logic [7:0] data;
    } plsr_link_s;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] data;
    } plsr_reg_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_STATUS = 4'b0010,
        ST_RECV = 4'b0100,
        ST_GAP = 4'b1000
    } plsr_state_e;
endpackage : plsr_pkg

// ---- rtl/plsr_port.sv ----
// Purpose: Device side of the parallel port: status transfers and packet receive
// Assumes: Serial-bus events arrive as one-cycle pulses synchronous to mclk
// Notes: Receive always wins over status; status resumes after the idle gap
// What this block does
// - Start status only when interface idle
// - Status code 01 with first bit pair
// - Hold status, two bits per cycle
// - Packet arrival cuts status to receive
// - Two cycles flags, eight with register
// - Full word after read or register news
// - Send node-number register after self-identification
// - Flags delivered once driven, then cleared
// - Register delivered only after all bits
// - Retry while anything remains pending
// - Idle ends status; gap between transfers
// - Bits 0,1 report arbitration, subaction gaps
// - Bit 2 bus reset, bit 3 interrupt
// - Bits 4-7 address, 8-15 contents
// - Data prefix starts receive with data-on
// - Speed code precedes packet data
// - Hold receive to last symbol, then idle
// - Forward every packet whose prefix comes while enabled and not in the gap cycle, no filtering
// - Speed code excluded from packet protection
// - Speed and data-on codes, fixed fill bits
// - Idle cycle after every receive
// - Null packet: data-on then idle only
// - Receive code is 10
module plsr_port #(
    parameter int DATA_W = 8
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    // Serial-bus side events
    input wire logic ev_arb_gap,
    input wire logic ev_sub_gap,
    input wire logic ev_bus_reset,
    input wire logic ev_interrupt,
    input wire logic ev_selfid_done,
    input wire logic [3:0] node_reg_addr,
    input wire logic [7:0] node_reg_data,
    input wire logic rd_req,
    input wire logic [3:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic rx_prefix,
    input wire logic rx_start,
    input wire logic [1:0] rx_speed,
    input wire logic rx_valid,
    input wire logic [DATA_W-1:0] rx_symbol,
    input wire logic rx_end,
    // Software port
    input wire logic [3:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [15:0] sw_rdata,
    // Link side
    output plsr_pkg::plsr_link_s link_q,
    output logic [1:0] iface_control_lines,
    output logic [DATA_W-1:0] link_data,
    output logic link_oe,
    output logic rd_busy
);
    plsr_pkg::plsr_state_e state_q;
    logic [3:0] flags_q;
    logic reg_pend_q;
    plsr_pkg::plsr_reg_s reg_q;
    logic [15:0] word_q;
    logic [2:0] cyc_q;
    logic full_q;
    logic [7:0] ctrl_q;
    logic [7:0] rx_cnt_q;
    logic [15:0] rdata_q;
    logic [1:0] ctl_q;
    logic [DATA_W-1:0] d_q;
    logic oe_q;
    logic [3:0] new_flags;
    logic [3:0] sent_flags;
    logic status_go;
    logic status_done;
    logic reg_done;
    logic enable;

    assign enable = ctrl_q[plsr_pkg::CTRL_ENABLE_BIT];
    // Flag positions follow the status word layout
    assign new_flags = {ev_interrupt, ev_bus_reset, ev_sub_gap, ev_arb_gap}
        | (sw_wr && sw_addr == plsr_pkg::REG_CTRL ?
           sw_wdata[plsr_pkg::CTRL_FLAGS_LSB +: 4] : 4'h0);
    // Start only from idle, never while a receive is arriving
    assign status_go = enable && state_q == plsr_pkg::ST_IDLE && !rx_prefix
        && ((|flags_q) || reg_pend_q);
    assign status_done = state_q == plsr_pkg::ST_STATUS && !rx_prefix
        && cyc_q == (full_q ? plsr_pkg::FULL_CYCLES : plsr_pkg::FLAG_CYCLES - 3'h1);
    assign reg_done = state_q == plsr_pkg::ST_STATUS && !rx_prefix
        && full_q && cyc_q == plsr_pkg::REG_LAST_CYCLE;

    // Flag bits driven on cycle 0 and 1 are delivered even if cut short
    always_comb begin
        sent_flags = 4'h0;
        if (status_go) begin
            sent_flags[1:0] = flags_q[1:0];
        end
        if (state_q == plsr_pkg::ST_STATUS && !rx_prefix && cyc_q == 3'h1) begin
            sent_flags[3:2] = word_q[3:2];
        end
    end

    // Pending flags: set wins over clear
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            flags_q <= 4'h0;
        end else if (clk_en) begin
            flags_q <= (flags_q & ~sent_flags) | new_flags;
        end
    end

    // Pending register report; new requests ignored until delivered
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_pend_q <= 1'b0;
            reg_q <= '0;
        end else if (clk_en) begin
            if (!reg_pend_q && ev_selfid_done) begin
                reg_pend_q <= 1'b1;
                reg_q <= '{addr: node_reg_addr, data: node_reg_data};
            end else if (!reg_pend_q && rd_req) begin
                reg_pend_q <= 1'b1;
                reg_q <= '{addr: rd_addr, data: rd_data};
            end else if (reg_done) begin
                reg_pend_q <= 1'b0;
            end
        end
    end

    // Interface sequencer
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= plsr_pkg::ST_IDLE;
            cyc_q <= 3'h0;
            full_q <= 1'b0;
            word_q <= 16'h0000;
        end else if (clk_en) begin
            case (state_q)
                plsr_pkg::ST_IDLE: begin
                    if (rx_prefix && enable) begin
                        state_q <= plsr_pkg::ST_RECV;
                    end else if (status_go) begin
                        state_q <= plsr_pkg::ST_STATUS;
                        cyc_q <= 3'h1;
                        full_q <= reg_pend_q;
                        word_q <= {reg_q.data, reg_q.addr, flags_q};
                    end
                end
                plsr_pkg::ST_STATUS: begin
                    if (rx_prefix) begin
                        state_q <= plsr_pkg::ST_RECV;
                    end else if (status_done) begin
                        state_q <= plsr_pkg::ST_GAP;
                    end else begin
                        cyc_q <= cyc_q + 3'h1;
                    end
                end
                plsr_pkg::ST_RECV: begin
                    if (rx_end) begin
                        state_q <= plsr_pkg::ST_GAP;
                    end
                end
                plsr_pkg::ST_GAP: begin
                    state_q <= plsr_pkg::ST_IDLE;
                end
                default: begin
                    state_q <= plsr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Speed code on the data lines; no CRC is computed here at all
    function automatic logic [7:0] speed_code(input logic [1:0] spd);
        case (spd)
            plsr_pkg::SPEED_200: speed_code = plsr_pkg::SPD_S200;
            plsr_pkg::SPEED_400: speed_code = plsr_pkg::SPD_S400;
            default: speed_code = plsr_pkg::SPD_S100;
        endcase
    endfunction : speed_code

    // Registered link lines
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctl_q <= plsr_pkg::CTL_IDLE;
            d_q <= '0;
            oe_q <= 1'b0;
        end else if (clk_en) begin
            oe_q <= enable;
            d_q <= '0;
            ctl_q <= plsr_pkg::CTL_IDLE;
            case (state_q)
                plsr_pkg::ST_IDLE: begin
                    if (rx_prefix && enable) begin
                        ctl_q <= plsr_pkg::CTL_RECEIVE;
                        d_q <= '1;
                    end else if (status_go) begin
                        ctl_q <= plsr_pkg::CTL_STATUS;
                        d_q[1:0] <= flags_q[1:0];
                    end
                end
                plsr_pkg::ST_STATUS: begin
                    if (rx_prefix) begin
                        ctl_q <= plsr_pkg::CTL_RECEIVE;
                        d_q <= '1;
                    end else begin
                        // Pair cyc_q goes out now; the last pair is driven before the idle gap
                        ctl_q <= plsr_pkg::CTL_STATUS;
                        d_q[1:0] <= word_q[{cyc_q, 1'b0} +: 2];
                    end
                end
                plsr_pkg::ST_RECV: begin
                    if (!rx_end) begin
                        ctl_q <= plsr_pkg::CTL_RECEIVE;
                        if (rx_start) begin
                            d_q <= DATA_W'(speed_code(rx_speed));
                        end else if (rx_valid) begin
                            d_q <= rx_symbol;
                        end else begin
                            d_q <= '1;
                        end
                    end
                end
                default: begin
                    ctl_q <= plsr_pkg::CTL_IDLE;
                end
            endcase
        end
    end

    // Software registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= plsr_pkg::CTRL_RESET;
            rx_cnt_q <= 8'h00;
            rdata_q <= 16'h0000;
        end else if (clk_en) begin
            if (sw_wr && sw_addr == plsr_pkg::REG_CTRL) begin
                ctrl_q <= {4'h0, sw_wdata[3:0]};
            end
            if (state_q == plsr_pkg::ST_RECV && rx_end) begin
                rx_cnt_q <= rx_cnt_q + 8'h01;
            end
            rdata_q <= 16'h0000;
            if (sw_rd) begin
                case (sw_addr)
                    plsr_pkg::REG_CTRL: rdata_q <= {8'h00, ctrl_q};
                    plsr_pkg::REG_STAT: rdata_q <= {7'h00, reg_pend_q, 4'h0, state_q};
                    plsr_pkg::REG_NODE: rdata_q <= {4'h0, reg_q.addr, reg_q.data};
                    plsr_pkg::REG_REPORT: rdata_q <= {3'h0, reg_pend_q, 8'h00, flags_q};
                    plsr_pkg::REG_RXCNT: rdata_q <= {8'h00, rx_cnt_q};
                    default: rdata_q <= 16'h0000;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rd_busy <= 1'b0;
        end else if (clk_en) begin
            rd_busy <= reg_pend_q;
        end
    end

    assign sw_rdata = rdata_q;
    assign link_q = '{ctl: ctl_q, data: d_q[7:0]};
    assign iface_control_lines = ctl_q;
    assign link_data = d_q;
    assign link_oe = oe_q;
endmodule : plsr_port

// ---- verif/plsr_port_props.sv ----
// Purpose: Link-side timing checks for plsr_port
// Assumes: clk_en held high
// Notes: Bound into every plsr_port
module plsr_port_props #(
    parameter int DATA_W = 8
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic rx_prefix,
    input wire logic rx_start,
    input wire logic [1:0] rx_speed,
    input wire logic rx_valid,
    input wire logic [DATA_W-1:0] rx_symbol,
    input wire logic rx_end,
    input wire logic [1:0] iface_control_lines,
    input wire logic [DATA_W-1:0] link_data
);
    wire logic st = iface_control_lines == plsr_pkg::CTL_STATUS;
    wire logic rx = iface_control_lines == plsr_pkg::CTL_RECEIVE;
    wire logic idl = iface_control_lines == plsr_pkg::CTL_IDLE;
    logic [3:0] run_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Consecutive status cycles seen so far
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            run_q <= 4'h0;
        end else begin
            run_q <= st ? run_q + 4'h1 : 4'h0;
        end
    end
    AST_STAT_MAX: assert property (run_q <= 4'h8)
        else $error("status run too long");
    AST_STAT_LEN: assert property (idl && run_q > 4'h0 |-> run_q inside {4'h2, 4'h8})
        else $error("status run neither 2 nor 8");
    AST_STAT_CUT: assert property (st && rx_prefix |=> rx)
        else $error("status not cut by receive");
    AST_RX_FIRST: assert property (rx && !$past(rx) |-> link_data == '1)
        else $error("receive without data-on");
    AST_SPEED: assert property (rx && rx_start && !rx_end |=> rx && link_data[7:0] ==
        ($past(rx_speed) == 2'h0 ? 8'h00 : $past(rx_speed) == 2'h1 ? 8'h40 : 8'h50))
        else $error("wrong speed code");
    AST_SYMBOL: assert property (rx && rx_valid && !rx_start && !rx_end |=>
        rx && link_data == $past(rx_symbol))
        else $error("symbol not forwarded");
    AST_RX_END: assert property (rx && rx_end |=> idl ##1 idl)
        else $error("no idle after receive");
    AST_ST_FILL: assert property (st |-> link_data[DATA_W-1:2] == '0)
        else $error("unused status lines not zero");
    COV_FULL: cover property (idl && run_q == 4'h8);
    COV_CUT: cover property (st && rx_prefix);
    COV_NULL: cover property (rx && rx_end && link_data == '1);
endmodule : plsr_port_props

bind plsr_port plsr_port_props #(.DATA_W(DATA_W)) u_plsr_port_props (
    .mclk, .resetn, .rx_prefix, .rx_start, .rx_speed, .rx_valid, .rx_symbol, .rx_end,
    .iface_control_lines, .link_data
);

// ---- verif/plsr_link_model.sv ----
// Purpose: Link-controller model assembling status words and packets
// Assumes: Lines sampled on every rising mclk
// Notes: A register word cut short by a receive is dropped
module plsr_link_model (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [1:0] ctl,
    input wire logic [7:0] data,
    output logic [15:0] st_word,
    output logic [15:0] reg_word,
    output logic [7:0] st_cnt,
    output logic [7:0] rx_spd,
    output logic [7:0] rx_sum,
    output logic [7:0] rx_len,
    output logic [7:0] rx_cnt
);
    logic [15:0] sh;
    logic [3:0] n;
    logic in_rx, spd_ok;
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            {sh, n, st_word, reg_word, st_cnt, in_rx, spd_ok} <= '0;
            {rx_spd, rx_sum, rx_len, rx_cnt} <= '0;
        end else begin
            if (ctl == plsr_pkg::CTL_STATUS) begin
                sh[2*n+:2] <= data[1:0];
                n <= n + 4'h1;
            end else if (n != 4'h0) begin
                {st_word, sh, n, st_cnt} <= {sh, 16'h0, 4'h0, st_cnt + 8'h1};
                reg_word <= (n == 4'h8) ? sh : reg_word;
            end
            in_rx <= ctl == plsr_pkg::CTL_RECEIVE;
            if (ctl != plsr_pkg::CTL_RECEIVE) begin
                rx_cnt <= rx_cnt + 8'(in_rx);
            end else if (!in_rx) begin
                {rx_spd, rx_sum, rx_len, spd_ok} <= {8'hff, 17'h0};
            end else if (spd_ok) begin
                {rx_sum, rx_len} <= {rx_sum + data, rx_len + 8'h1};
            end else if (data != 8'hff) begin
                {rx_spd, spd_ok} <= {data, 1'b1};
            end
        end
    end
endmodule : plsr_link_model

// ---- verif/tb_plsr_port.sv ----
// Purpose: Self-checking bench for plsr_port
// Assumes: clk_en held high
// Notes: Seeded random reports and packets
module tb_plsr_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, resetn = 1'b0, sel = 1'b0, rd_req = 1'b0, rx_prefix = 1'b0;
    logic rx_start = 1'b0, rx_valid = 1'b0, rx_end = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0;
    logic [3:0] ev = 4'h0, sw_addr = 4'h0, rd_addr = 4'h0, nd_addr = 4'h0;
    logic [1:0] rx_speed = 2'h0, ctl;
    logic [7:0] nd_data = 8'h0, rd_data = 8'h0, rx_symbol = 8'h0, sw_wdata = 8'h0, data;
    logic [15:0] sw_rdata, st_word, reg_word;
    logic [7:0] st_cnt, rx_spd, rx_sum, rx_len, rx_cnt, sum;
    logic [9:0] lq;
    logic oe, busy;
    int error_cnt = 0, checks = 0;
    always #50 mclk = ~mclk;
    plsr_port u_plsr_port (
        .mclk, .resetn, .clk_en(1'b1), .ev_arb_gap(ev[0]), .ev_sub_gap(ev[1]),
        .ev_bus_reset(ev[2]), .ev_interrupt(ev[3]), .ev_selfid_done(sel),
        .node_reg_addr(nd_addr), .node_reg_data(nd_data), .rd_req, .rd_addr, .rd_data,
        .rx_prefix, .rx_start, .rx_speed, .rx_valid, .rx_symbol, .rx_end, .sw_addr,
        .sw_wdata, .sw_wr, .sw_rd, .sw_rdata, .link_q(lq), .iface_control_lines(ctl),
        .link_data(data), .link_oe(oe), .rd_busy(busy)
    );
    plsr_link_model u_plsr_link_model (
        .mclk, .resetn, .ctl, .data, .st_word, .reg_word, .st_cnt, .rx_spd, .rx_sum,
        .rx_len, .rx_cnt
    );
    task automatic results;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic sw_op(input logic wr, input logic [3:0] a, output logic [15:0] q);
        @(posedge mclk);
        {sw_wr, sw_rd, sw_addr, sw_wdata} <= {wr, !wr, a, 8'h01};
        @(posedge mclk);
        {sw_wr, sw_rd} <= 2'b00;
        #1 q = sw_rdata;
    endtask : sw_op
    task automatic wait_st;
        logic [7:0] c;
        c = st_cnt;
        repeat (60) if (st_cnt == c) @(posedge mclk);
        #1;
        if (st_cnt == c) begin
            error_cnt++;
            results();
        end
    endtask : wait_st
    task automatic rx_pkt(input logic [1:0] s, input logic [7:0] n);
        logic [7:0] j, b;
        sum = 8'h00;
        @(posedge mclk);
        rx_prefix <= 1'b1;
        @(posedge mclk);
        {rx_prefix, rx_start, rx_speed} <= {1'b0, n != 8'h0, s};
        for (j = 8'h0; j < n; j++) begin
            b = 8'($urandom);
            sum = sum + b;
            @(posedge mclk);
            {rx_start, rx_valid, rx_symbol} <= {2'b01, b};
        end
        @(posedge mclk);
        {rx_start, rx_valid, rx_end} <= 3'b001;
        @(posedge mclk);
        rx_end <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : rx_pkt
    initial begin
        logic [15:0] q;
        logic [3:0] a;
        logic [7:0] d;
        a = 4'($urandom(32'h0d9f));
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        sw_op(1'b1, 4'h0, q);
        sw_op(1'b0, 4'h0, q);
        chk(q, 16'h0001);
        sw_op(1'b0, 4'hf, q);
        chk(q, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            a = (i < 4) ? 4'h1 << i : 4'hf;
            @(posedge mclk);
            ev <= a;
            @(posedge mclk);
            ev <= 4'h0;
            wait_st();
            chk(st_word, {12'h0, a});
        end
        for (int i = 0; i < 3; i++) begin
            a = 4'($urandom);
            d = 8'($urandom);
            @(posedge mclk);
            {nd_addr, nd_data, rd_addr, rd_data} <= {a, d, a, d};
            {sel, rd_req, ev} <= {i == 0, i > 0, 3'h0, i == 2};
            @(posedge mclk);
            {sel, rd_req, ev} <= 6'h0;
            if (i == 2) begin
                repeat (3) @(posedge mclk);
                rx_pkt(2'h1, 8'h2);
            end
            wait_st();
            chk(reg_word, {d, a, 4'h0});
        end
        for (int i = 0; i < 8; i++) begin
            a = 4'(i % 3);
            d = (i == 0) ? 8'h0 : 8'($urandom_range(5, 1));
            rx_pkt(a[1:0], d);
            q = (a == 4'h0) ? 16'h00 : (a == 4'h1) ? 16'h40 : 16'h50;
            chk({8'h0, rx_spd}, (d == 8'h0) ? 16'hff : q);
            chk({8'h0, rx_sum}, {8'h0, sum});
            chk({8'h0, rx_len}, {8'h0, d});
        end
        chk({8'h0, rx_cnt}, 16'h9);
        sw_op(1'b0, 4'h4, q);
        chk(q, 16'h0009);
        chk({6'h0, lq}, {6'h0, plsr_pkg::CTL_IDLE, 8'h00});
        chk({15'h0, oe}, 16'h0001);
        chk({15'h0, busy}, 16'h0000);
        results();
    end
endmodule : tb_plsr_port
